//--- hdl/rscs_pkg.sv
// package: strap field positions, decode types and register map for the strap sampler
package rscs_pkg;

	// ----------------------------------------------------------------
	// strap bus, tx_data and boot address field positions
	// ----------------------------------------------------------------
	localparam int BOOT_ROM_EN_BIT    = 0;
	localparam int DRAM_CAL_BIT       = 1;
	localparam int ROM_ADDR_LO        = 2;
	localparam int ARBITER_BIT        = 4;
	localparam int REG_BASE_BIT       = 5;
	localparam int CPU_BUS_LO         = 6;
	localparam int CPU_CAL_BIT        = 8;
	localparam int PCI0_CAL_BIT       = 12;
	localparam int PCI1_CAL_BIT       = 13;
	localparam int BOOT_WIDTH_LO      = 14;
	localparam int PCI_RETRY_BIT      = 16;
	localparam int DRAM_CLK_BIT       = 18;
	localparam int DRAM_EDGE_BIT      = 19;
	localparam int DRAM_PIPE_A_BIT    = 20;
	localparam int DRAM_PIPE_B_BIT    = 21;
	localparam int DRAM_READ_LO       = 22;
	localparam int GIG3_EN_BIT        = 25;
	localparam int PCI1_DLL_LO        = 26;
	localparam int PCI0_DLL_LO        = 29;
	localparam int PLL_TUNE_LO        = 2;
	localparam int CORE_BYPASS_BIT    = 1;
	localparam int PORT_IF_BIT        = 0;
	localparam int TEST_CAL_BIT       = 7;
	localparam int DRAM_PLL_PWR_BIT   = 2;

	// ----------------------------------------------------------------
	// decoded values
	// ----------------------------------------------------------------
	localparam logic [6:0]  ROM_ADDR_BASE   = 7'h50;        // 1010000
	localparam logic [31:0] REG_BASE_LOW    = 32'h14000000;
	localparam logic [31:0] REG_BASE_HIGH   = 32'hf1000000;
	localparam logic [1:0]  PIPE_TWO_CODE   = 2'h1;         // bit20=0, bit21=1
	localparam logic [1:0]  PIPE_THREE_CODE = 2'h3;

	typedef enum logic [1:0] {RSCS_BUS_LEGACY, RSCS_BUS_PIPELINED, RSCS_BUS_RSVD} rscs_bus_t;
	typedef enum logic [1:0] {RSCS_W8, RSCS_W16, RSCS_W32, RSCS_WRSVD} rscs_width_t;
	typedef enum logic [2:0] {RSCS_DLL_OFF, RSCS_DLL_PCI66, RSCS_DLL_PCIX133, RSCS_DLL_PCIX66,
		RSCS_DLL_RSVD} rscs_dll_t;

	// raw sampled strap pins
	typedef struct packed {
		logic [31:0] strap_bus;
		logic [7:0]  tx_data0;
		logic [4:0]  tx_data1;
		logic [2:0]  boot_address_strap;
	} rscs_straps_t;

	// decoded configuration
	typedef struct packed {
		logic        serial_boot_rom_en;
		logic        dram_cal_en;
		logic        cpu_cal_en;
		logic        pci0_cal_en;
		logic        pci1_cal_en;
		logic [6:0]  serial_boot_rom_addr;
		logic        arbiter_en;
		logic [31:0] reg_base;
		rscs_bus_t   cpu_bus;
		rscs_width_t boot_width;
		logic        pci_retry_en;
		logic        dram_sync_clk;
		logic        dram_rise_launch;
		logic [1:0]  dram_pipe_stages;   // 2 or 3, 0 = reserved code
		logic        dram_async;
		logic        gig3_en;
		rscs_dll_t   pci0_dll;
		rscs_dll_t   pci1_dll;
		logic        port0_pcs;
		logic        port1_pcs;
		logic        dram_pll_up;
		logic        test_cal_bypass;
		logic        core_pll_bypass;
		logic [2:0]  core_pll_tune;
	} rscs_cfg_t;

	// ----------------------------------------------------------------
	// apb register map (word offsets as byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_STRAP_BUS = 8'h00;
	localparam logic [7:0]  REG_STRAP_AUX = 8'h04;
	localparam logic [7:0]  REG_STATUS    = 8'h08;
	localparam logic [7:0]  REG_CONTROL   = 8'h0c;
	localparam logic [31:0] RD_UNMAPPED   = 32'h00000000;

endpackage : rscs_pkg

//--- hdl/rscs_strap_sampler.sv
// strap sampler: latches configuration pins at reset release and decodes mode settings
`timescale 1ns/1ps
// What this block does
// RQ1 - latch straps at reset release, decode them
// RQ2 - bit 0 enables serial boot rom init
// RQ3 - calibration straps: 0 disables, 1 enables
// RQ4 - bits 3:2 pick boot rom address
// RQ5 - bit 4 enables internal cpu bus arbiter
// RQ6 - bit 5 picks internal register base
// RQ7 - bits 7:6 pick cpu bus protocol
// RQ8 - bits 15:14 pick boot device width
// RQ9 - bit 16 enables pci retry
// RQ10 - bit 18 picks dram clock ratio
// RQ11 - bit 19 picks dram launch edge
// RQ12 - bits 20:21 pick dram pipeline depth
// RQ13 - bits 24:22 select sync or async dram
// RQ14 - bit 25 enables fourth gigabit port
// RQ15 - pci dll fields decode mode and speed
// RQ16 - board presents pci pattern each pci reset
// RQ17 - board sets straps lacking fixed defaults
// RQ18 - tx_data bit 0 picks gmii or pcs
// RQ19 - boot address bit 2 powers dram pll
// RQ20 - tx_data0 bit 7 bypasses test calibration
// RQ21 - tx_data1 bit 1 is core pll bypass
// RQ22 - bypass strap 1 bypasses core pll; the control register override bit forces the bypass off instead
// RQ23 - tx_data1 bits 4:2 tune core pll
// RQ24 - latched values hold until next reset
module rscs_strap_sampler (
	input  wire logic                 clk_i,
	input  wire logic                 srst_i,
	input  wire logic                 pci_rst_i,
	input  wire logic [31:0]          strap_bus_i,
	input  wire logic [7:0]           tx_data0_i,
	input  wire logic [4:0]           tx_data1_i,
	input  wire logic [2:0]           boot_address_strap_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic                      pready_o,
	output logic                      pslverr_o,
	output logic [31:0]               prdata_o,
	output rscs_pkg::rscs_cfg_t       cfg_o,
	output logic                      cfg_valid_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                  in_reset;
		logic                  in_pci_reset;
		logic                  valid;
		logic [3:0]            sample_count;
		rscs_pkg::rscs_straps_t raw;
		rscs_pkg::rscs_cfg_t   cfg;
		logic                  override_en;
		logic                  pready;
		logic                  pslverr;
		logic [31:0]           prdata;
	} rscs_state_t;

	rscs_state_t state;
	rscs_state_t next_state;
	rscs_pkg::rscs_straps_t pins;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic rscs_pkg::rscs_dll_t rscs_dll_decode(input logic [2:0] code);
		case (code)
			3'h0:    rscs_dll_decode = rscs_pkg::RSCS_DLL_OFF;
			3'h1:    rscs_dll_decode = rscs_pkg::RSCS_DLL_PCI66;
			3'h5:    rscs_dll_decode = rscs_pkg::RSCS_DLL_PCIX133;
			3'h6:    rscs_dll_decode = rscs_pkg::RSCS_DLL_PCIX66;
			default: rscs_dll_decode = rscs_pkg::RSCS_DLL_RSVD;
		endcase
	endfunction : rscs_dll_decode

	function automatic rscs_pkg::rscs_cfg_t rscs_decode(input rscs_pkg::rscs_straps_t s);
		rscs_pkg::rscs_cfg_t c;
		logic [1:0]          pipe;
		c = '0;
		c.serial_boot_rom_en = s.strap_bus[rscs_pkg::BOOT_ROM_EN_BIT];                          // [RQ2]
		c.dram_cal_en        = s.strap_bus[rscs_pkg::DRAM_CAL_BIT];                             // [RQ3]
		c.cpu_cal_en         = s.strap_bus[rscs_pkg::CPU_CAL_BIT];                              // [RQ3]
		c.pci0_cal_en        = s.strap_bus[rscs_pkg::PCI0_CAL_BIT];                             // [RQ3]
		c.pci1_cal_en        = s.strap_bus[rscs_pkg::PCI1_CAL_BIT];                             // [RQ3]
		c.serial_boot_rom_addr = rscs_pkg::ROM_ADDR_BASE
			| {5'h00, s.strap_bus[rscs_pkg::ROM_ADDR_LO +: 2]};                                 // [RQ4]
		c.arbiter_en         = s.strap_bus[rscs_pkg::ARBITER_BIT];                              // [RQ5]
		c.reg_base           = s.strap_bus[rscs_pkg::REG_BASE_BIT] ? rscs_pkg::REG_BASE_HIGH
			: rscs_pkg::REG_BASE_LOW;                                                            // [RQ6]
		case (s.strap_bus[rscs_pkg::CPU_BUS_LO +: 2])                                           // [RQ7]
			2'h0:    c.cpu_bus = rscs_pkg::RSCS_BUS_LEGACY;
			2'h1:    c.cpu_bus = rscs_pkg::RSCS_BUS_PIPELINED;
			default: c.cpu_bus = rscs_pkg::RSCS_BUS_RSVD;
		endcase
		c.boot_width = rscs_pkg::rscs_width_t'(s.strap_bus[rscs_pkg::BOOT_WIDTH_LO +: 2]);     // [RQ8]
		c.pci_retry_en       = s.strap_bus[rscs_pkg::PCI_RETRY_BIT];                            // [RQ9]
		c.dram_sync_clk      = s.strap_bus[rscs_pkg::DRAM_CLK_BIT];                             // [RQ10]
		c.dram_rise_launch   = s.strap_bus[rscs_pkg::DRAM_EDGE_BIT];                            // [RQ11]
		// field is printed 20:21, so bit 20 is the high code bit
		pipe = {s.strap_bus[rscs_pkg::DRAM_PIPE_A_BIT], s.strap_bus[rscs_pkg::DRAM_PIPE_B_BIT]};
		case (pipe)                                                                             // [RQ12]
			rscs_pkg::PIPE_TWO_CODE:   c.dram_pipe_stages = 2'h2;
			rscs_pkg::PIPE_THREE_CODE: c.dram_pipe_stages = 2'h3;
			default:                   c.dram_pipe_stages = 2'h0;
		endcase
		// only 000 and 100 mean synchronous; every other code runs async
		c.dram_async = s.strap_bus[rscs_pkg::DRAM_READ_LO +: 2] != 2'h0;                        // [RQ13]
		c.gig3_en            = s.strap_bus[rscs_pkg::GIG3_EN_BIT];                              // [RQ14]
		c.pci1_dll = rscs_dll_decode(s.strap_bus[rscs_pkg::PCI1_DLL_LO +: 3]);                  // [RQ15]
		c.pci0_dll = rscs_dll_decode(s.strap_bus[rscs_pkg::PCI0_DLL_LO +: 3]);                  // [RQ15]
		c.port0_pcs          = s.tx_data0[rscs_pkg::PORT_IF_BIT];                               // [RQ18]
		c.port1_pcs          = s.tx_data1[rscs_pkg::PORT_IF_BIT];                               // [RQ18]
		c.dram_pll_up        = s.boot_address_strap[rscs_pkg::DRAM_PLL_PWR_BIT];                // [RQ19]
		c.test_cal_bypass    = s.tx_data0[rscs_pkg::TEST_CAL_BIT];                              // [RQ20]
		c.core_pll_bypass    = s.tx_data1[rscs_pkg::CORE_BYPASS_BIT];                           // [RQ21] [RQ22]
		c.core_pll_tune      = s.tx_data1[rscs_pkg::PLL_TUNE_LO +: 3];                          // [RQ23]
		rscs_decode = c;
	endfunction : rscs_decode

	assign pins = '{strap_bus: strap_bus_i, tx_data0: tx_data0_i, tx_data1: tx_data1_i,
		boot_address_strap: boot_address_strap_i};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// sampling is on the first clock where reset is seen released; pins
	// are taken as synchronous so no extra settle stage is added
	always_comb
	begin
		next_state              = state;
		next_state.in_reset     = 1'b0;
		next_state.in_pci_reset = pci_rst_i;
		next_state.pready       = 1'b0;
		next_state.pslverr      = 1'b0;
		if (state.in_reset)
		begin
			// reset just released: take every strap once [RQ1]
			next_state.raw          = pins;
			next_state.cfg          = rscs_decode(pins);
			next_state.valid        = 1'b1;
			next_state.sample_count = state.sample_count + 4'h1;
		end
		else if (state.in_pci_reset && !pci_rst_i)
		begin
			// pci reset release: only the pci dll fields are refreshed [RQ16]
			next_state.raw.strap_bus[31:26] = strap_bus_i[31:26];
			next_state.cfg.pci1_dll = rscs_dll_decode(strap_bus_i[rscs_pkg::PCI1_DLL_LO +: 3]);
			next_state.cfg.pci0_dll = rscs_dll_decode(strap_bus_i[rscs_pkg::PCI0_DLL_LO +: 3]);
			next_state.sample_count = state.sample_count + 4'h1;
		end
		// otherwise the latch holds; later pin activity is ignored [RQ24]

		// apb slave: one wait state, answer in the access phase
		if (psel_i && penable_i && !state.pready)
		begin
			next_state.pready = 1'b1;
			case (paddr_i)
				rscs_pkg::REG_STRAP_BUS: next_state.prdata = state.raw.strap_bus;
				rscs_pkg::REG_STRAP_AUX: next_state.prdata = {16'h0000, state.raw.tx_data0,
					state.raw.tx_data1, state.raw.boot_address_strap};
				rscs_pkg::REG_STATUS: next_state.prdata = {24'h000000, state.sample_count,
					state.cfg.core_pll_bypass, state.cfg.dram_pll_up, state.cfg.serial_boot_rom_en,
					state.valid};
				rscs_pkg::REG_CONTROL:
				begin
					next_state.prdata = {31'h00000000, state.override_en};
					if (pwrite_i)
						next_state.override_en = pwdata_i[0];
				end
				default:
				begin
					next_state.prdata  = rscs_pkg::RD_UNMAPPED;
					next_state.pslverr = 1'b1;
				end
			endcase
		end
		if (srst_i)
		begin
			next_state          = '0;
			next_state.in_reset = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		state <= next_state;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// override forces the core pll bypass off so software can recover a bad strap
	rscs_pkg::rscs_cfg_t out_cfg;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			out_cfg <= '0;
		else
		begin
			out_cfg <= next_state.cfg;
			if (next_state.override_en)
				out_cfg.core_pll_bypass <= 1'b0;                                                // [RQ22]
		end
	end

	assign cfg_o       = out_cfg;
	assign cfg_valid_o = state.valid;
	assign pready_o    = state.pready;
	assign pslverr_o   = state.pslverr;
	assign prdata_o    = state.prdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_sample_on_release: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(state.in_reset) |-> state.raw == $past(pins) && state.valid)          // [RQ1]
		else $error("straps not captured at reset release");
	a_hold_after_sample: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid && !state.in_reset && !$past(state.in_reset) && !$fell(state.in_pci_reset)
		|-> $stable(state.raw))                                                      // [RQ24]
		else $error("latched straps changed without reset");
	a_base_decode: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid |-> state.cfg.reg_base == (state.raw.strap_bus[5] ? 32'hf1000000 : 32'h14000000)) // [RQ6]
		else $error("register base decode wrong");
	a_rom_addr: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid |-> state.cfg.serial_boot_rom_addr == {5'h14, state.raw.strap_bus[3:2]}) // [RQ4]
		else $error("boot rom address decode wrong");
	a_pipe_depth: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid && state.raw.strap_bus[21:20] == 2'h3 |-> state.cfg.dram_pipe_stages == 2'h3) // [RQ12]
		else $error("pipeline depth decode wrong");
	a_dll_pcix133: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid && state.raw.strap_bus[31:29] == 3'h5 |-> state.cfg.pci0_dll == rscs_pkg::RSCS_DLL_PCIX133) // [RQ15]
		else $error("pci dll decode wrong");
	a_cpu_bus_mode: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid && state.raw.strap_bus[7:6] == 2'h1 |-> state.cfg.cpu_bus == rscs_pkg::RSCS_BUS_PIPELINED) // [RQ7]
		else $error("cpu bus mode decode wrong");
	// the output copy and the override flag move on the same edge, so compare in one cycle
	a_pll_bypass: assert property (@(posedge clk_i) disable iff (srst_i)
		state.valid && !state.override_en |-> cfg_o.core_pll_bypass == state.cfg.core_pll_bypass) // [RQ22]
		else $error("core pll bypass not applied");

endmodule : rscs_strap_sampler

//--- bench/rscs_strap_board.sv
// board model: strap resistors, jumpers and carrier reset pattern on the shared pins
`timescale 1ns/1ps
module rscs_strap_board (
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  pci_rst_i,
	input  wire logic                  tie_i,
	input  wire rscs_pkg::rscs_straps_t pattern_i,
	output rscs_pkg::rscs_straps_t      straps_o
);
	// ----------------------------------------------------------------
	// pattern during reset, bus traffic otherwise
	// ----------------------------------------------------------------
	logic                   held_q = 1'b1;
	logic [31:0]            cnt_q  = 32'h0;
	rscs_pkg::rscs_straps_t pat;
	// keep the pattern one edge past release, the sampling edge
	always_ff @(posedge clk_i)
	begin
		held_q <= srst_i | pci_rst_i;
		cnt_q  <= cnt_q + 32'h1;
	end
	// fixed board ties; traffic flips every cycle so a late sample shows
	always_comb
	begin
		pat = pattern_i;
		if (tie_i)
		begin
			pat.strap_bus[0]  = 1'b0;
			pat.strap_bus[4]  = 1'b1;
			pat.strap_bus[25] = 1'b0;
		end
		straps_o = (srst_i | pci_rst_i | held_q) ? pat : ~pat ^ {cnt_q, cnt_q[15:0]};
	end
endmodule : rscs_strap_board

//--- bench/rscs_strap_sampler_tb.sv
// testbench: strap capture, decode, hold, pci resample and apb registers
`timescale 1ns/1ps
module rscs_strap_sampler_tb;
	logic                   clk_i   = 1'b0;
	logic                   srst_i  = 1'b1;
	logic                   pci_rst = 1'b0;
	logic                   tie     = 1'b0;
	logic                   psel    = 1'b0;
	logic                   pen     = 1'b0;
	logic                   pwr     = 1'b0;
	logic [7:0]             paddr   = 8'h00;
	logic [31:0]            pwdata  = 32'h0;
	logic [31:0]            rd;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   perr;
	logic                   err;
	logic                   cvalid;
	rscs_pkg::rscs_straps_t pat     = '0;
	rscs_pkg::rscs_straps_t pins;
	rscs_pkg::rscs_cfg_t    cfg;
	int                     err_total = 0;
	int                     tests_run = 0;
	always #12.5 clk_i = ~clk_i;
	rscs_strap_board board (.clk_i(clk_i), .srst_i(srst_i), .pci_rst_i(pci_rst), .tie_i(tie),
		.pattern_i(pat), .straps_o(pins));
	rscs_strap_sampler uut (.clk_i(clk_i), .srst_i(srst_i), .pci_rst_i(pci_rst),
		.strap_bus_i(pins.strap_bus), .tx_data0_i(pins.tx_data0), .tx_data1_i(pins.tx_data1),
		.boot_address_strap_i(pins.boot_address_strap), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(perr),
		.prdata_o(prdata), .cfg_o(cfg), .cfg_valid_o(cvalid));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task test_done;
		$display("mismatches %0d in %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task chk32(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %0t: value %h expected %h", $time, g, e);
		end
	endtask : chk32
	task chk_cfg(input rscs_pkg::rscs_cfg_t g, input rscs_pkg::rscs_cfg_t e);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %0t: config %h expected %h", $time, g, e);
		end
	endtask : chk_cfg
	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk_i);
			if (pready === 1'b1)
				break;
		end
		if (n == 40)
		begin
			err_total++;
			test_done;
		end
		rd   = prdata;
		err  = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	function automatic rscs_pkg::rscs_dll_t dll(input logic [2:0] c);
		case (c)
			3'h0:    dll = rscs_pkg::RSCS_DLL_OFF;
			3'h1:    dll = rscs_pkg::RSCS_DLL_PCI66;
			3'h5:    dll = rscs_pkg::RSCS_DLL_PCIX133;
			3'h6:    dll = rscs_pkg::RSCS_DLL_PCIX66;
			default: dll = rscs_pkg::RSCS_DLL_RSVD;
		endcase
	endfunction : dll
	// expected decode worked out from the strap table
	function automatic rscs_pkg::rscs_cfg_t exp_cfg(input rscs_pkg::rscs_straps_t p);
		logic [31:0] s;
		logic [1:0]  pc;
		s  = p.strap_bus;
		pc = {s[20], s[21]};
		exp_cfg = '0;
		exp_cfg.serial_boot_rom_en   = s[0];
		exp_cfg.dram_cal_en          = s[1];
		exp_cfg.cpu_cal_en           = s[8];
		exp_cfg.pci0_cal_en          = s[12];
		exp_cfg.pci1_cal_en          = s[13];
		exp_cfg.serial_boot_rom_addr = {5'h14, s[3:2]};
		exp_cfg.arbiter_en           = s[4];
		exp_cfg.reg_base             = s[5] ? 32'hf1000000 : 32'h14000000;
		exp_cfg.cpu_bus              = (s[7:6] == 2'h0) ? rscs_pkg::RSCS_BUS_LEGACY :
			(s[7:6] == 2'h1) ? rscs_pkg::RSCS_BUS_PIPELINED : rscs_pkg::RSCS_BUS_RSVD;
		exp_cfg.boot_width           = rscs_pkg::rscs_width_t'(s[15:14]);
		exp_cfg.pci_retry_en         = s[16];
		exp_cfg.dram_sync_clk        = s[18];
		exp_cfg.dram_rise_launch     = s[19];
		exp_cfg.dram_pipe_stages     = (pc == 2'h1) ? 2'h2 : (pc == 2'h3) ? 2'h3 : 2'h0;
		exp_cfg.dram_async           = s[23:22] != 2'h0;
		exp_cfg.gig3_en              = s[25];
		exp_cfg.pci0_dll             = dll(s[31:29]);
		exp_cfg.pci1_dll             = dll(s[28:26]);
		exp_cfg.port0_pcs            = p.tx_data0[0];
		exp_cfg.port1_pcs            = p.tx_data1[0];
		exp_cfg.dram_pll_up          = p.boot_address_strap[2];
		exp_cfg.test_cal_bypass      = p.tx_data0[7];
		exp_cfg.core_pll_bypass      = p.tx_data1[1];
		exp_cfg.core_pll_tune        = p.tx_data1[4:2];
	endfunction : exp_cfg
	// reset with a pattern, then check capture, readback and hold under traffic
	task run(input rscs_pkg::rscs_straps_t p, input logic t);
		@(posedge clk_i);
		pat    <= p;
		tie    <= t;
		srst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk_cfg(cfg, exp_cfg(p));
		chk32({31'h0, cvalid}, 32'h1);
		apb(1'b0, rscs_pkg::REG_STRAP_BUS, 32'h0);
		chk32(rd, p.strap_bus);
		apb(1'b0, rscs_pkg::REG_STRAP_AUX, 32'h0);
		chk32(rd, {16'h0, p.tx_data0, p.tx_data1, p.boot_address_strap});
		apb(1'b0, rscs_pkg::REG_STATUS, 32'h0);
		chk32({31'h0, rd[0]}, 32'h1);
		chk32({24'h0, rd[7:0]}, {24'h0, 4'h1, p.tx_data1[1], p.boot_address_strap[2], p.strap_bus[0], 1'b1});
		repeat (20) @(posedge clk_i);
		chk_cfg(cfg, exp_cfg(p));
	endtask : run
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rscs_pkg::rscs_straps_t p;
		rscs_pkg::rscs_cfg_t    e;
		// board defaults, width and dll given explicitly by the system
		p = '{strap_bus: 32'ha437b17a, tx_data0: 8'h00, tx_data1: 5'h00, boot_address_strap: 3'h7};
		run(p, 1'b1);
		// every code of every field except boot rom address (codes 2 and 1 only), single straps toggled by turns
		for (int i = 0; i < 8; i++)
		begin
			p.strap_bus        = 32'ha437b17a ^ (i[0] ? 32'h020d313f : 32'h0);
			p.strap_bus[7:6]   = i[1:0];
			p.strap_bus[15:14] = i[2:1];
			p.strap_bus[20]    = i[1];
			p.strap_bus[21]    = i[0];
			p.strap_bus[24:22] = i[2:0];
			p.strap_bus[28:26] = i[2:0];
			p.strap_bus[31:29] = ~i[2:0];
			p.tx_data0         = {i[0], 6'h15, i[1]};
			p.tx_data1         = {i[2:0], i[0], i[1]};
			p.boot_address_strap = {~i[0], i[1], i[2]};
			run(p, 1'b0);
		end
		// bypass override in control, strap sampled as 1
		apb(1'b1, rscs_pkg::REG_CONTROL, 32'h1);
		apb(1'b0, rscs_pkg::REG_CONTROL, 32'h0);
		chk32({31'h0, rd[0]}, 32'h1);
		@(posedge clk_i);
		chk32({31'h0, cfg.core_pll_bypass}, 32'h0);
		apb(1'b1, rscs_pkg::REG_CONTROL, 32'h0);
		repeat (2) @(posedge clk_i);
		chk32({31'h0, cfg.core_pll_bypass}, 32'h1);
		// read-only place ignores writes, unmapped place refuses
		apb(1'b1, rscs_pkg::REG_STRAP_BUS, ~p.strap_bus);
		apb(1'b0, rscs_pkg::REG_STRAP_BUS, 32'h0);
		chk32(rd, p.strap_bus);
		chk32({31'h0, err}, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk32({31'h0, err}, 32'h1);
		chk32(rd, rscs_pkg::RD_UNMAPPED);
		// pci reset brings a new dll pattern; other settings keep
		e = exp_cfg(p);
		p.strap_bus[31:26] = 6'h0e;
		@(posedge clk_i);
		pat     <= p;
		pci_rst <= 1'b1;
		repeat (4) @(posedge clk_i);
		pci_rst <= 1'b0;
		repeat (3) @(posedge clk_i);
		e.pci0_dll = rscs_pkg::RSCS_DLL_PCI66;
		e.pci1_dll = rscs_pkg::RSCS_DLL_PCIX66;
		chk_cfg(cfg, e);
		test_done;
	end
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		test_done;
	end
endmodule : rscs_strap_sampler_tb
